/* File: hw/osr_status.sv */
// Implementation choices: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ns
module osr_status #(
  parameter int CW = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [CW-1:0] oper_cond,
  input wire logic spoll_req,
  input wire logic dev_clear,
  output logic srq,
  output logic [7:0] spoll_byte,
  output logic spoll_done,
  output logic parser_reset,
  output logic output_flush,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // elaboration check: condition width must hold bit 3 and fit a word
  if (CW < 4 || CW > 32) begin : g_bad_cw
    $error("osr_status: CW must be 4 to 32");
  end

  ////////////////////////////////////////////////////////////////////////////
  localparam int IRQ_W_L = osr_pkg::IRQ_W;

  // whole module state
  typedef struct packed {
    logic [CW-1:0] c1, c2, c3, cond;
    logic [CW-1:0] ptr, ntr, evt, ena;
    logic [7:0] sre;
    logic mss_prev, rqs, srq;
    logic p1, p2, p3, pseen;
    logic d1, d2, d3, dseen;
    logic [7:0] pbyte;
    logic pdone, prst, flush;
    logic [IRQ_W_L-1:0] istat, imask;
    logic irq;
    logic aw_ok, w_ok, awready, wready, bvalid, arready, rvalid;
    logic [7:0] awaddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
  } osr_state_t;

  osr_state_t st_ff, nxt_st;
  logic [CW-1:0] rise, fall, new_evt, evt_clr, wmask;
  logic [31:0] rd_val;
  logic sum, mss, do_wr, do_rd, poll_hit, dcl_hit, rd_err, wr_err, cls_hit;
  logic [IRQ_W_L-1:0] iset, iclr;
  logic [7:0] stb;

  ////////////////////////////////////////////////////////////////////////////
  // byte-lane write mask over the condition width
  for (genvar i = 0; i < CW; i++) begin : g_mask
    assign wmask[i] = st_ff.wstrb[i/8];
  end

  ////////////////////////////////////////////////////////////////////////////
  // status byte view and read mux
  always_comb begin
    sum = |(st_ff.evt & st_ff.ena);
    stb = 8'h00;
    stb[osr_pkg::STB_OPER] = sum;
    stb[osr_pkg::STB_RQS] = st_ff.rqs;
    rd_err = 1'b0;
    rd_val = 32'h0000_0000;
    case (s_axi_araddr)
      osr_pkg::A_COND: rd_val[CW-1:0] = st_ff.cond;
      osr_pkg::A_PTR: rd_val[CW-1:0] = st_ff.ptr;
      osr_pkg::A_NTR: rd_val[CW-1:0] = st_ff.ntr;
      osr_pkg::A_EVT: rd_val[CW-1:0] = st_ff.evt;
      osr_pkg::A_ENA: rd_val[CW-1:0] = st_ff.ena;
      osr_pkg::A_STB: rd_val[7:0] = stb;
      osr_pkg::A_SRE: rd_val[7:0] = st_ff.sre;
      osr_pkg::A_CMD: rd_val = 32'h0000_0000;
      osr_pkg::A_ISTAT: rd_val[IRQ_W_L-1:0] = st_ff.istat;
      osr_pkg::A_IMASK: rd_val[IRQ_W_L-1:0] = st_ff.imask;
      default: rd_err = 1'b1;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb begin
    nxt_st = st_ff;
    // three-stage synchronisers; a change counts once stage 2 and 3 agree
    nxt_st.c1 = oper_cond;
    nxt_st.c2 = st_ff.c1;
    nxt_st.c3 = st_ff.c2;
    nxt_st.p1 = spoll_req;
    nxt_st.p2 = st_ff.p1;
    nxt_st.p3 = st_ff.p2;
    nxt_st.d1 = dev_clear;
    nxt_st.d2 = st_ff.d1;
    nxt_st.d3 = st_ff.d2;
    for (int i = 0; i < CW; i++) begin
      if (st_ff.c2[i] == st_ff.c3[i]) begin
        nxt_st.cond[i] = st_ff.c3[i];
      end
    end
    if (st_ff.p2 == st_ff.p3) begin
      nxt_st.pseen = st_ff.p3;
    end
    if (st_ff.d2 == st_ff.d3) begin
      nxt_st.dseen = st_ff.d3;
    end
    poll_hit = nxt_st.pseen & ~st_ff.pseen;
    dcl_hit = nxt_st.dseen & ~st_ff.dseen;

    // transition filters into the event register
    rise = nxt_st.cond & ~st_ff.cond & st_ff.ptr;
    fall = ~nxt_st.cond & st_ff.cond & st_ff.ntr;
    new_evt = rise | fall;

    // write channel: address and data taken in either order
    if (s_axi_awvalid && st_ff.awready) begin
      nxt_st.aw_ok = 1'b1;
      nxt_st.awready = 1'b0;
      nxt_st.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st_ff.wready) begin
      nxt_st.w_ok = 1'b1;
      nxt_st.wready = 1'b0;
      nxt_st.wdata = s_axi_wdata;
      nxt_st.wstrb = s_axi_wstrb;
    end
    do_wr = st_ff.aw_ok & st_ff.w_ok & ~st_ff.bvalid;
    wr_err = 1'b0;
    evt_clr = '0;
    cls_hit = 1'b0;
    iclr = '0;
    nxt_st.pdone = 1'b0;
    nxt_st.prst = 1'b0;
    nxt_st.flush = 1'b0;
    if (do_wr) begin
      nxt_st.aw_ok = 1'b0;
      nxt_st.w_ok = 1'b0;
      nxt_st.bvalid = 1'b1;
      case (st_ff.awaddr)
        osr_pkg::A_PTR: nxt_st.ptr = (st_ff.ptr & ~wmask) | (st_ff.wdata[CW-1:0] & wmask);
        osr_pkg::A_NTR: nxt_st.ntr = (st_ff.ntr & ~wmask) | (st_ff.wdata[CW-1:0] & wmask);
        osr_pkg::A_ENA: nxt_st.ena = (st_ff.ena & ~wmask) | (st_ff.wdata[CW-1:0] & wmask);
        osr_pkg::A_SRE: begin
          if (st_ff.wstrb[0]) begin
            nxt_st.sre = st_ff.wdata[7:0];
          end
        end
        osr_pkg::A_IMASK: begin
          if (st_ff.wstrb[0]) begin
            nxt_st.imask = st_ff.wdata[IRQ_W_L-1:0];
          end
        end
        osr_pkg::A_CMD: begin
          if (st_ff.wstrb[0] && st_ff.wdata[osr_pkg::CMD_CLS]) begin
            evt_clr = '1;
            cls_hit = 1'b1;
          end
          if (st_ff.wstrb[0] && st_ff.wdata[osr_pkg::CMD_RST]) begin
            nxt_st.ptr = osr_pkg::PTR_RST[CW-1:0];
            nxt_st.ntr = osr_pkg::NTR_RST[CW-1:0];
            nxt_st.ena = osr_pkg::ENA_RST[CW-1:0];
            nxt_st.sre = osr_pkg::SRE_RST;
          end
          if (st_ff.wstrb[0] && st_ff.wdata[osr_pkg::CMD_DCL]) begin
            nxt_st.prst = 1'b1;
            nxt_st.flush = 1'b1;
          end
        end
        osr_pkg::A_COND, osr_pkg::A_EVT, osr_pkg::A_STB, osr_pkg::A_ISTAT: wr_err = 1'b0;
        default: wr_err = 1'b1;
      endcase
      nxt_st.bresp = wr_err ? osr_pkg::RESP_ERR : osr_pkg::RESP_OK;
    end
    if (st_ff.bvalid && s_axi_bready) begin
      nxt_st.bvalid = 1'b0;
      nxt_st.awready = 1'b1;
      nxt_st.wready = 1'b1;
    end

    // read channel; event and interrupt status clear on read
    do_rd = s_axi_arvalid & st_ff.arready;
    if (do_rd) begin
      nxt_st.arready = 1'b0;
      nxt_st.rvalid = 1'b1;
      nxt_st.rdata = rd_val;
      nxt_st.rresp = rd_err ? osr_pkg::RESP_ERR : osr_pkg::RESP_OK;
      if (s_axi_araddr == osr_pkg::A_EVT) begin
        evt_clr = '1;
      end
      if (s_axi_araddr == osr_pkg::A_ISTAT) begin
        iclr = '1;
      end
    end
    if (st_ff.rvalid && s_axi_rready) begin
      nxt_st.rvalid = 1'b0;
      nxt_st.arready = 1'b1;
    end

    // device clear from the bus side
    if (dcl_hit) begin
      nxt_st.prst = 1'b1;
      nxt_st.flush = 1'b1;
    end

    // event register: a new event wins over a clear in the same cycle
    nxt_st.evt = (st_ff.evt & ~evt_clr) | new_evt;

    // service request; a fresh rise wins over a poll or clear-status
    mss = |(nxt_st.evt & nxt_st.ena) & nxt_st.sre[osr_pkg::STB_OPER];
    nxt_st.mss_prev = mss;
    if (mss && !st_ff.mss_prev) begin
      nxt_st.rqs = 1'b1;
    end else if (!mss || poll_hit || cls_hit) begin
      nxt_st.rqs = 1'b0;
    end
    nxt_st.srq = nxt_st.rqs;

    // serial poll answers with the status byte as it stands
    if (poll_hit) begin
      nxt_st.pbyte = stb;
      nxt_st.pdone = 1'b1;
    end

    // interrupt status, set wins over clear
    iset = '0;
    iset[osr_pkg::IRQ_EVT] = |new_evt;
    iset[osr_pkg::IRQ_SRQ] = nxt_st.rqs & ~st_ff.rqs;
    iset[osr_pkg::IRQ_POLL] = poll_hit;
    nxt_st.istat = (st_ff.istat & ~iclr) | iset;
    nxt_st.irq = |(nxt_st.istat & st_ff.imask);
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register with synchronous reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff <= '0;
      st_ff.ptr <= osr_pkg::PTR_RST[CW-1:0];
      st_ff.ntr <= osr_pkg::NTR_RST[CW-1:0];
      st_ff.ena <= osr_pkg::ENA_RST[CW-1:0];
      st_ff.sre <= osr_pkg::SRE_RST;
      st_ff.awready <= 1'b1;
      st_ff.wready <= 1'b1;
      st_ff.arready <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs straight from the state flops
  assign s_axi_awready = st_ff.awready;
  assign s_axi_wready = st_ff.wready;
  assign s_axi_bvalid = st_ff.bvalid;
  assign s_axi_bresp = st_ff.bresp;
  assign s_axi_arready = st_ff.arready;
  assign s_axi_rvalid = st_ff.rvalid;
  assign s_axi_rdata = st_ff.rdata;
  assign s_axi_rresp = st_ff.rresp;
  assign srq = st_ff.srq;
  assign spoll_byte = st_ff.pbyte;
  assign spoll_done = st_ff.pdone;
  assign parser_reset = st_ff.prst;
  assign output_flush = st_ff.flush;
  assign irq = st_ff.irq;

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sweep_end_evt_a: assert property (
    (st_ff.ntr[3] && st_ff.cond[3] && !nxt_st.cond[3]) |=> st_ff.evt[3])
    else $error("falling sweep bit did not set event bit 3");

  no_rise_evt_a: assert property (
    (st_ff.ptr == '0 && fall == '0) |=> (st_ff.evt & ~$past(st_ff.evt)) == '0)
    else $error("event set by a rise with its filter cleared");

  summary_gate_a: assert property (
    st_ff.rvalid && $past(s_axi_araddr) == osr_pkg::A_STB && $past(do_rd) |->
      st_ff.rdata[osr_pkg::STB_OPER] == $past(|(st_ff.evt & st_ff.ena)))
    else $error("status byte bit 7 not the enabled event summary");

  srq_raise_a: assert property (
    (!st_ff.mss_prev && mss) |=> srq)
    else $error("service request not raised");

  poll_byte_a: assert property (
    poll_hit |=> spoll_done && spoll_byte == $past(stb))
    else $error("poll answer wrong");

  cls_clear_a: assert property (
    (cls_hit && new_evt == '0) |=> st_ff.evt == '0 && !srq)
    else $error("clear-status left events set");

  dcl_flush_a: assert property (
    dcl_hit |=> parser_reset && output_flush)
    else $error("device clear not acted on");

  rst_default_a: assert property (
    (do_wr && st_ff.awaddr == osr_pkg::A_CMD && st_ff.wstrb[0]
      && st_ff.wdata[osr_pkg::CMD_RST]) |=> st_ff.ena == osr_pkg::ENA_RST[CW-1:0]
      && st_ff.ptr == osr_pkg::PTR_RST[CW-1:0] && st_ff.sre == osr_pkg::SRE_RST)
    else $error("reset command left settings");

  srq_drop_a: assert property (
    (srq && (poll_hit || !mss)) |=> !srq)
    else $error("service request held too long");

  poll_srq_a: assert property (
    (poll_hit && st_ff.mss_prev) |=> !srq)
    else $error("service request kept after the poll");

  evt_rc_a: assert property (
    (do_rd && s_axi_araddr == osr_pkg::A_EVT && new_evt == '0) |=> st_ff.evt == '0)
    else $error("event register not cleared by its read");

  istat_rc_a: assert property (
    (do_rd && s_axi_araddr == osr_pkg::A_ISTAT && iset == '0) |=> st_ff.istat == '0)
    else $error("interrupt status not cleared by its read");

  irq_mask_a: assert property (
    (st_ff.imask == '0) |=> !irq)
    else $error("interrupt raised while fully masked");

endmodule // osr_status

/* File: hw/osr_pkg.sv */
package osr_pkg;
  // register byte addresses
  localparam logic [7:0] A_COND = 8'h00;
  localparam logic [7:0] A_PTR = 8'h04;
  localparam logic [7:0] A_NTR = 8'h08;
  localparam logic [7:0] A_EVT = 8'h0C;
  localparam logic [7:0] A_ENA = 8'h10;
  localparam logic [7:0] A_STB = 8'h14;
  localparam logic [7:0] A_SRE = 8'h18;
  localparam logic [7:0] A_CMD = 8'h1C;
  localparam logic [7:0] A_ISTAT = 8'h20;
  localparam logic [7:0] A_IMASK = 8'h24;
  // command register bits
  localparam int CMD_CLS = 0;
  localparam int CMD_DCL = 1;
  localparam int CMD_RST = 2;
  // status byte fields
  localparam int STB_OPER = 7;
  localparam int STB_RQS = 6;
  // interrupt status bits
  localparam int IRQ_EVT = 0;
  localparam int IRQ_SRQ = 1;
  localparam int IRQ_POLL = 2;
  localparam int IRQ_W = 3;
  // defaults after reset or reset command, and the bus response codes
  localparam logic [31:0] PTR_RST = 32'hFFFF_FFFF;
  localparam logic [31:0] NTR_RST = 32'h0000_0000;
  localparam logic [31:0] ENA_RST = 32'h0000_0000;
  localparam logic [7:0] SRE_RST = 8'h00;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
endpackage : osr_pkg

/* File: dv/osr_ctrl_model.sv */
`timescale 1ns/1ns
// bus controller: answers every service request with one serial poll
module osr_ctrl_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic srq,
  input wire logic spoll_done,
  input wire logic [7:0] spoll_byte,
  input wire logic dclr_go,
  output logic spoll_req,
  output logic dev_clear,
  output logic [7:0] poll_byte,
  output logic [7:0] poll_cnt
);
  // poll held until the device reports the byte, then released
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      spoll_req <= 1'b0;
      dev_clear <= 1'b0;
      poll_byte <= 8'h0;
      poll_cnt <= 8'h0;
    end else begin
      dev_clear <= dclr_go;
      if (spoll_req && spoll_done) begin
        spoll_req <= 1'b0;
        poll_byte <= spoll_byte;
        poll_cnt <= poll_cnt + 8'h1;
      end else if (srq && !spoll_req) begin
        spoll_req <= 1'b1;
      end
    end
  end
endmodule // osr_ctrl_model

/* File: dv/tb_top.sv */
`timescale 1ns/1ns
module tb_top;
  logic aclk = 0;
  logic aresetn = 0;
  logic [7:0] awaddr = 0, araddr = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = 0;
  logic [3:0] wstrb = 0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, d;
  logic [1:0] r;
  logic [15:0] cond = 0;
  logic spoll_req, dev_clear, srq, spoll_done, parser_reset, output_flush, irq;
  logic dclr_go = 0;
  logic [15:0] prst_n = 16'h0000, flush_n = 16'h0000;
  logic [7:0] spoll_byte, poll_byte, poll_cnt;
  int bad_count = 0;
  int n_compared = 0;
  always #5 aclk = ~aclk;
  osr_status i_osr_status (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .oper_cond(cond), .spoll_req(spoll_req),
    .dev_clear(dev_clear), .srq(srq), .spoll_byte(spoll_byte),
    .spoll_done(spoll_done), .parser_reset(parser_reset),
    .output_flush(output_flush), .irq(irq));
  osr_ctrl_model i_osr_ctrl_model (.aclk(aclk), .aresetn(aresetn), .srq(srq),
    .spoll_done(spoll_done), .spoll_byte(spoll_byte), .dclr_go(dclr_go),
    .spoll_req(spoll_req), .dev_clear(dev_clear), .poll_byte(poll_byte),
    .poll_cnt(poll_cnt));
  // pulse counters for the device-clear outputs, read where they have settled
  always @(negedge aclk) begin
    if (parser_reset === 1'b1) prst_n <= prst_n + 16'h0001;
    if (output_flush === 1'b1) flush_n <= flush_n + 16'h0001;
  end
  ////////////////////////////////////////////////////////////////////////////
  // shared helpers
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      bad_count++;
      $display("BAD %s exp %h seen %h", nm, e, s);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask
  // ready and valid are sampled at negedge: flop outputs equal the next edge
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic pa, pw, ta, tw;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    pa = 1'b1;
    pw = 1'b1;
    while (pa || pw) begin
      @(negedge aclk);
      ta = pa && awready;
      tw = pw && wready;
      @(posedge aclk);
      if (ta) begin
        awvalid <= 1'b0;
        pa = 1'b0;
      end
      if (tw) begin
        wvalid <= 1'b0;
        pw = 1'b0;
      end
    end
    do @(negedge aclk); while (bvalid !== 1'b1);
    r = bresp;
    @(posedge aclk);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(negedge aclk); while (arready !== 1'b1);
    @(posedge aclk);
    arvalid <= 1'b0;
    do @(negedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    @(posedge aclk);
    rready <= 1'b0;
  endtask
  task automatic wait_flag(input int lim);
    int n;
    n = 0;
    do begin @(negedge aclk); n++; end while (parser_reset !== 1'b1 && n < lim);
  endtask
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_map();
    rd(osr_pkg::A_PTR);
    chk("ptr rst", d, {16'h0000, osr_pkg::PTR_RST[15:0]});
    rd(8'h40);
    chk("unmapped rd", {30'h0, r}, {30'h0, osr_pkg::RESP_ERR});
    wr(8'h40, 32'h0000_0001);
    chk("unmapped wr", {30'h0, r}, {30'h0, osr_pkg::RESP_ERR});
  endtask
  task automatic t_sweep();
    int n;
    wr(osr_pkg::A_NTR, 32'h0000_0008);
    wr(osr_pkg::A_PTR, 32'h0000_0000);
    wr(osr_pkg::A_ENA, 32'h0000_0008);
    wr(osr_pkg::A_SRE, 32'h0000_0080);
    wr(osr_pkg::A_IMASK, 32'h0000_0007);
    cond <= 16'h0008;
    cyc(10);
    rd(osr_pkg::A_EVT);
    chk("evt on start", d, 32'h0000_0000);
    @(negedge aclk);
    chk("srq on start", {31'h0, srq}, 32'h0000_0000);
    @(posedge aclk);
    cond <= 16'h0000;
    n = 0;
    do begin
      @(negedge aclk);
      n++;
    end while (poll_cnt == 8'h00 && n < 80);
    chk("poll summary", {24'h0, poll_byte & 8'h80}, 32'h0000_0080);
    cyc(3);
    @(negedge aclk);
    chk("srq after poll", {31'h0, srq}, 32'h0000_0000);
    chk("irq set", {31'h0, irq}, 32'h0000_0001);
    wr(osr_pkg::A_IMASK, 32'h0000_0000);
    cyc(2);
    @(negedge aclk);
    chk("irq masked", {31'h0, irq}, 32'h0000_0000);
    wr(osr_pkg::A_IMASK, 32'h0000_0007);
    cyc(2);
    rd(osr_pkg::A_ISTAT);
    chk("istat", d, 32'h0000_0007);
    cyc(2);
    @(negedge aclk);
    chk("irq cleared", {31'h0, irq}, 32'h0000_0000);
    rd(osr_pkg::A_EVT);
    chk("evt on end", d, 32'h0000_0008);
  endtask
  task automatic t_ena_cls();
    wr(osr_pkg::A_ENA, 32'h0000_0000);
    cond <= 16'h0008;
    cyc(10);
    cond <= 16'h0000;
    cyc(10);
    rd(osr_pkg::A_STB);
    chk("stb masked", d & 32'h0000_0080, 32'h0000_0000);
    @(negedge aclk);
    chk("srq masked", {31'h0, srq}, 32'h0000_0000);
    wr(osr_pkg::A_ENA, 32'h0000_0008);
    rd(osr_pkg::A_STB);
    chk("stb enabled", d & 32'h0000_0080, 32'h0000_0080);
    wr(osr_pkg::A_CMD, 32'h0000_0001);
    rd(osr_pkg::A_EVT);
    chk("evt cls", d, 32'h0000_0000);
    rd(osr_pkg::A_STB);
    chk("stb cls", d, 32'h0000_0000);
  endtask
  task automatic t_dcl();
    @(posedge aclk);
    dclr_go <= 1'b1;
    wait_flag(20);
    chk("flush pin", {30'h0, parser_reset, output_flush}, 32'h0000_0003);
    @(posedge aclk);
    dclr_go <= 1'b0;
    wr(osr_pkg::A_CMD, 32'h0000_0002);
    cyc(2);
    @(negedge aclk);
    chk("flush count", {prst_n, flush_n}, 32'h0002_0002);
  endtask
  task automatic t_rst();
    wr(osr_pkg::A_PTR, 32'h0000_0000);
    wr(osr_pkg::A_NTR, 32'h0000_0008);
    wr(osr_pkg::A_SRE, 32'h0000_0080);
    wr(osr_pkg::A_CMD, 32'h0000_0004);
    rd(osr_pkg::A_PTR);
    chk("ptr def", d, {16'h0000, osr_pkg::PTR_RST[15:0]});
    rd(osr_pkg::A_NTR);
    chk("ntr def", d, {16'h0000, osr_pkg::NTR_RST[15:0]});
    rd(osr_pkg::A_ENA);
    chk("ena def", d, {16'h0000, osr_pkg::ENA_RST[15:0]});
    rd(osr_pkg::A_SRE);
    chk("sre def", d, {24'h00_0000, osr_pkg::SRE_RST});
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // main sequence and watchdog
  initial begin
    cyc(8);
    aresetn <= 1;
    t_map(); t_sweep(); t_ena_cls(); t_dcl(); t_rst();
    finish_test();
  end
  initial begin
    #200000;
    bad_count++;
    finish_test();
  end
endmodule // tb_top
